// >>> rtl/mff_defines.svh
`ifndef MFF_DEFINES_SVH
`define MFF_DEFINES_SVH
// ----------------------------------------
// Frame layout
// ----------------------------------------
`define MFF_FRAME_LEN 8'd222
`define MFF_LAST_IDX 8'd221
`define MFF_PRE_END 8'd8
`define MFF_DST_END 8'd14
`define MFF_SRC_END 8'd20
`define MFF_LEN_HI 8'd20
`define MFF_LEN_LO 8'd21
`define MFF_LEN_VAL 16'h00C4
`define MFF_LLC_DSAP 8'd22
`define MFF_LLC_SSAP 8'd23
`define MFF_LLC_CTL 8'd24
`define MFF_LLC_SAP 8'hAA
`define MFF_LLC_CTL_VAL 8'h03
`define MFF_SNAP_ZERO 8'd25
`define MFF_SNAP_OPEN 8'd28
`define MFF_CFG0 8'd30
`define MFF_CFG1 8'd31
`define MFF_CNT 8'd34
`define MFF_MASK 8'd38
`define MFF_SLOT 8'd42
`define MFF_SLOT_END 8'd170
`define MFF_FCS 8'd218
`define MFF_PRE_BYTE 8'h55
`define MFF_SFD_BYTE 8'hD5
`define MFF_VERSION 4'h3
`define MFF_RATE_MAX 4'h1
`define MFF_CRC_INIT 32'hFFFFFFFF
`define MFF_CRC_POLY 32'hEDB88320
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define MFF_R_CTRL 12'h000
`define MFF_R_STAT 12'h004
`define MFF_R_TXMASK 12'h008
`define MFF_R_FCNT 12'h00C
`define MFF_R_DSTHI 12'h010
`define MFF_R_DSTLO 12'h014
`define MFF_R_SRCHI 12'h018
`define MFF_R_SRCLO 12'h01C
`define MFF_R_SNAP 12'h020
`define MFF_R_RXMASK 12'h024
`define MFF_R_RXCNT 12'h028
`define MFF_R_TXSLOT 12'h080
`define MFF_R_RXSLOT 12'h100
`define MFF_R_END 12'h180
`define MFF_CTRL_RST 16'h0000
`endif

// >>> rtl/mff_formatter.sv
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`include "mff_defines.svh"
// Function
// [RULE1] Frames are exactly 222 octets long
// [RULE2] Send preamble, MAC, LLC, SNAP, payload, FCS
// [RULE3] FCS is Ethernet CRC-32 after preamble
// [RULE4] Length field always carries 196
// [RULE5] LLC carries AA, AA, 03
// [RULE6] SNAP starts with three zero octets
// [RULE7] Generate FCS on send, check on receive
// [RULE8] Multi-octet values go most significant first
// [RULE9] Payload sections sit at fixed octets
// [RULE10] Reserved config bits sent zero, ignored
// [RULE11] Version field sent as 3
// [RULE12] Check version and config before payload use
// [RULE13] Encoding field selects slot word format
// [RULE14] One sample per slot, MSB first
// [RULE15] Narrow samples left-justified, low bits cleared
// [RULE16] Encoding 2 carries 24-bit audio plus flags
// [RULE17] Encoding 2 bit layout, express at bit 0
// [RULE18] Express samples forwarded unaltered when processing
// [RULE19] Raw octets keep their order
// [RULE20] Copy-protected data never retransmitted
// [RULE21] Base rate copied from uplink when following
// [RULE22] Bad frames dropped with error pulse
module mff_formatter (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic tx_frame_req,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_last,
    output logic rx_frame_ok,
    output logic rx_frame_err
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        mff_pkg::mff_tx_state_t tx_st;
        logic [7:0] tx_idx;
        logic [7:0] tx_data;
        logic [31:0] tx_crc;
        logic [31:0] fcnt;
        logic [15:0] ctrl;
        logic [31:0] tx_mask;
        logic [47:0] dst;
        logic [47:0] src;
        logic [15:0] snap;
        logic [7:0] rx_idx;
        logic [31:0] rx_crc;
        logic [31:0] rx_fcs;
        logic rx_bad;
        logic [7:0] rx_cfg0_s;
        logic [3:0] rx_rate_s;
        logic [31:0] rx_mask_s;
        logic [31:0] rx_cnt_s;
        logic bank;
        logic rx_seen;
        logic [7:0] rx_cfg0;
        logic [3:0] rx_rate;
        logic [31:0] rx_mask;
        logic [31:0] rx_cnt;
        logic [15:0] err_cnt;
        logic ok_p;
        logic err_p;
        logic aw;
        logic [11:0] aaddr;
        logic [31:0] rdata;
    } mff_state_t;

    mff_state_t s_q;
    mff_state_t s_d;
    logic [31:0] tx_mem [0:31];
    logic [7:0] rx_mem [0:255];

    // Control fields
    logic tx_en;
    logic [1:0] enc;
    logic cp_tx;
    logic proc_mode;
    logic rate_follow;
    logic [3:0] rate_sw;
    logic [4:0] width;
    assign tx_en = s_q.ctrl[0];
    assign enc = s_q.ctrl[2:1];
    assign cp_tx = s_q.ctrl[3];
    assign proc_mode = s_q.ctrl[4];
    assign rate_follow = s_q.ctrl[5];
    assign rate_sw = s_q.ctrl[9:6];
    assign width = s_q.ctrl[14:10];

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int k = 0; k < 8; k++) begin
            r = (r[0] ^ d[k]) ? ((r >> 1) ^ `MFF_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte

    function automatic logic [7:0] msb_byte(input logic [31:0] w, input logic [1:0] b);
        return 8'(w >> {~b, 3'b000});
    endfunction : msb_byte

    // ----------------------------------------
    // Transmit slot word assembly
    // ----------------------------------------
    function automatic logic [31:0] rx_word(input logic bk, input logic [4:0] sl);
        return {rx_mem[{bk, sl, 2'd0}], rx_mem[{bk, sl, 2'd1}],
                rx_mem[{bk, sl, 2'd2}], rx_mem[{bk, sl, 2'd3}]};
    endfunction : rx_word

    function automatic logic [31:0] slot_word(input logic [4:0] sl);
        logic [31:0] w;
        logic [31:0] keep;
        logic [31:0] fw;
        w = tx_mem[sl];
        fw = rx_word(s_q.bank, sl);
        keep = (width == 5'd0) ? 32'hFFFFFFFF : ~(32'hFFFFFFFF >> width);
        if (enc == 2'(mff_pkg::MFF_ENC_RAW)) begin
            keep = 32'hFFFFFFFF; // [RULE19]
        end else if (enc == 2'(mff_pkg::MFF_ENC_A24)) begin
            keep = keep | 32'h000000FF; // [RULE16] [RULE17]
        end
        w = w & keep; // [RULE15]
        // Forwarding only for audio frames that were not copy protected
        if (proc_mode && s_q.rx_seen && s_q.rx_cfg0[5:4] == 2'(mff_pkg::MFF_ENC_A24)
            && !s_q.rx_cfg0[7] && fw[0]) begin
            w = fw; // [RULE18] [RULE20]
        end
        return w;
    endfunction : slot_word

    function automatic logic [7:0] tx_byte(input logic [7:0] i, input logic [31:0] crc);
        logic [7:0] b;
        logic [7:0] o;
        logic [3:0] rate;
        b = 8'h00;
        rate = rate_follow ? s_q.rx_rate : rate_sw; // [RULE21]
        if (i < 8'd7) begin
            b = `MFF_PRE_BYTE; // [RULE2]
        end else if (i < `MFF_PRE_END) begin
            b = `MFF_SFD_BYTE;
        end else if (i < `MFF_DST_END) begin
            o = 8'(`MFF_DST_END - 8'd1 - i);
            b = 8'(s_q.dst >> {o, 3'b000}); // [RULE8]
        end else if (i < `MFF_SRC_END) begin
            o = 8'(`MFF_SRC_END - 8'd1 - i);
            b = 8'(s_q.src >> {o, 3'b000});
        end else if (i == `MFF_LEN_HI) begin
            b = 8'(`MFF_LEN_VAL >> 8); // [RULE4]
        end else if (i == `MFF_LEN_LO) begin
            b = 8'(`MFF_LEN_VAL);
        end else if (i < `MFF_LLC_CTL) begin
            b = `MFF_LLC_SAP; // [RULE5]
        end else if (i == `MFF_LLC_CTL) begin
            b = `MFF_LLC_CTL_VAL;
        end else if (i < `MFF_SNAP_OPEN) begin
            b = 8'h00; // [RULE6]
        end else if (i < `MFF_CFG0) begin
            b = (i == `MFF_SNAP_OPEN) ? s_q.snap[15:8] : s_q.snap[7:0];
        end else if (i == `MFF_CFG0) begin
            b = {cp_tx | s_q.rx_cfg0[7], 1'b0, enc, `MFF_VERSION}; // [RULE10] [RULE11] [RULE13]
        end else if (i == `MFF_CFG1) begin
            b = {4'h0, rate};
        end else if (i < `MFF_CNT) begin
            b = 8'h00;
        end else if (i < `MFF_MASK) begin
            b = msb_byte(s_q.fcnt, 2'(i - `MFF_CNT)); // [RULE9]
        end else if (i < `MFF_SLOT) begin
            b = msb_byte(s_q.tx_mask, 2'(i - `MFF_MASK));
        end else if (i < `MFF_SLOT_END) begin
            o = 8'(i - `MFF_SLOT);
            b = msb_byte(slot_word(o[6:2]), o[1:0]); // [RULE14]
        end else if (i < `MFF_FCS) begin
            b = 8'h00;
        end else begin
            b = msb_byte(~crc, 2'(i - `MFF_FCS)); // [RULE7]
        end
        return b;
    endfunction : tx_byte

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    logic a_take;
    logic tx_step;
    logic [31:0] crc_nx;
    logic [31:0] rcrc_nx;
    logic rx_wr;
    logic [7:0] rx_wa;
    logic tx_wr;
    logic [4:0] tx_wa;
    logic [11:0] ra;
    logic [31:0] rd;

    assign a_take = hsel && htrans[1] && hready;
    assign tx_step = s_q.tx_st == mff_pkg::MFF_TX_SEND && tx_ready;
    assign ra = haddr[11:0];

    always_comb begin
        s_d = s_q;
        s_d.ok_p = 1'b0;
        s_d.err_p = 1'b0;
        crc_nx = s_q.tx_crc;
        rcrc_nx = s_q.rx_crc;
        rx_wr = 1'b0;
        rx_wa = 8'h00;
        tx_wr = 1'b0;
        tx_wa = 5'h00;
        rd = 32'h00000000;
        // Transmit sequencer
        case (s_q.tx_st)
            mff_pkg::MFF_TX_IDLE: begin
                if (tx_en && tx_frame_req) begin
                    s_d.tx_st = mff_pkg::MFF_TX_SEND;
                    s_d.tx_idx = 8'h00;
                    s_d.tx_crc = `MFF_CRC_INIT;
                    s_d.tx_data = tx_byte(8'h00, `MFF_CRC_INIT);
                end
            end
            mff_pkg::MFF_TX_SEND: begin
                if (tx_ready) begin
                    if (s_q.tx_idx >= `MFF_PRE_END && s_q.tx_idx < `MFF_FCS) begin
                        crc_nx = crc_byte(s_q.tx_crc, s_q.tx_data); // [RULE3]
                    end
                    s_d.tx_crc = crc_nx;
                    if (s_q.tx_idx == `MFF_LAST_IDX) begin
                        s_d.tx_st = mff_pkg::MFF_TX_IDLE; // [RULE1]
                        s_d.fcnt = s_q.fcnt + 32'd1;
                    end else begin
                        s_d.tx_idx = s_q.tx_idx + 8'd1;
                        s_d.tx_data = tx_byte(s_q.tx_idx + 8'd1, crc_nx);
                    end
                end
            end
            default: s_d.tx_st = mff_pkg::MFF_TX_IDLE;
        endcase
        // Receive checker
        if (rx_valid) begin
            s_d.rx_idx = (s_q.rx_idx == 8'hFF) ? s_q.rx_idx : s_q.rx_idx + 8'd1;
            if (s_q.rx_idx >= `MFF_PRE_END && s_q.rx_idx < `MFF_FCS) begin
                rcrc_nx = crc_byte(s_q.rx_crc, rx_data);
            end
            s_d.rx_crc = rcrc_nx;
            if (s_q.rx_idx == `MFF_LEN_HI && rx_data != 8'(`MFF_LEN_VAL >> 8)) begin
                s_d.rx_bad = 1'b1; // [RULE22]
            end
            if (s_q.rx_idx == `MFF_LEN_LO && rx_data != 8'(`MFF_LEN_VAL)) begin
                s_d.rx_bad = 1'b1;
            end
            if (s_q.rx_idx == `MFF_CFG0) begin
                s_d.rx_cfg0_s = {rx_data[7], 1'b0, rx_data[5:0]}; // [RULE10]
                if (rx_data[3:0] != `MFF_VERSION) begin
                    s_d.rx_bad = 1'b1; // [RULE12]
                end
            end
            if (s_q.rx_idx == `MFF_CFG1) begin
                s_d.rx_rate_s = rx_data[3:0];
                if (rx_data[3:0] > `MFF_RATE_MAX) begin
                    s_d.rx_bad = 1'b1; // [RULE12]
                end
            end
            if (s_q.rx_idx >= `MFF_CNT && s_q.rx_idx < `MFF_MASK) begin
                s_d.rx_cnt_s = {s_q.rx_cnt_s[23:0], rx_data};
            end
            if (s_q.rx_idx >= `MFF_MASK && s_q.rx_idx < `MFF_SLOT) begin
                s_d.rx_mask_s = {s_q.rx_mask_s[23:0], rx_data};
            end
            if (s_q.rx_idx >= `MFF_SLOT && s_q.rx_idx < `MFF_SLOT_END) begin
                rx_wr = 1'b1;
                rx_wa = {~s_q.bank, 7'(s_q.rx_idx - `MFF_SLOT)}; // [RULE19]
            end
            if (s_q.rx_idx >= `MFF_FCS) begin
                s_d.rx_fcs = {s_q.rx_fcs[23:0], rx_data};
            end
            if (rx_last) begin
                s_d.rx_idx = 8'h00;
                s_d.rx_crc = `MFF_CRC_INIT;
                s_d.rx_bad = 1'b0;
                if (!s_q.rx_bad && s_q.rx_idx == `MFF_LAST_IDX
                    && {s_q.rx_fcs[23:0], rx_data} == ~s_q.rx_crc) begin // [RULE7] [RULE1]
                    s_d.bank = ~s_q.bank;
                    s_d.rx_seen = 1'b1;
                    s_d.rx_cfg0 = s_q.rx_cfg0_s;
                    s_d.rx_rate = s_q.rx_rate_s;
                    s_d.rx_mask = s_q.rx_mask_s;
                    s_d.rx_cnt = s_q.rx_cnt_s;
                    s_d.ok_p = 1'b1;
                end else begin
                    s_d.err_p = 1'b1; // [RULE22]
                    s_d.err_cnt = s_q.err_cnt + 16'd1;
                end
            end
        end
        // AHB data phase: write
        s_d.aw = 1'b0;
        if (s_q.aw) begin
            if (s_q.aaddr == `MFF_R_CTRL) begin
                s_d.ctrl = hwdata[15:0];
            end else if (s_q.aaddr == `MFF_R_TXMASK) begin
                s_d.tx_mask = hwdata;
            end else if (s_q.aaddr == `MFF_R_DSTHI) begin
                s_d.dst[47:32] = hwdata[15:0];
            end else if (s_q.aaddr == `MFF_R_DSTLO) begin
                s_d.dst[31:0] = hwdata;
            end else if (s_q.aaddr == `MFF_R_SRCHI) begin
                s_d.src[47:32] = hwdata[15:0];
            end else if (s_q.aaddr == `MFF_R_SRCLO) begin
                s_d.src[31:0] = hwdata;
            end else if (s_q.aaddr == `MFF_R_SNAP) begin
                s_d.snap = hwdata[15:0];
            end else if (s_q.aaddr >= `MFF_R_TXSLOT && s_q.aaddr < `MFF_R_RXSLOT) begin
                tx_wr = 1'b1;
                tx_wa = s_q.aaddr[6:2];
            end
        end
        // AHB address phase: latch write, prepare read data
        if (a_take) begin
            s_d.aw = hwrite;
            s_d.aaddr = {ra[11:2], 2'b00};
            if (ra[11:2] == `MFF_R_CTRL >> 2) begin
                rd = {16'h0000, s_q.ctrl};
            end else if (ra[11:2] == `MFF_R_STAT >> 2) begin
                rd = {s_q.err_cnt, 2'b00, s_q.rx_rate, s_q.rx_cfg0, s_q.rx_seen, 1'b0};
            end else if (ra[11:2] == `MFF_R_TXMASK >> 2) begin
                rd = s_q.tx_mask;
            end else if (ra[11:2] == `MFF_R_FCNT >> 2) begin
                rd = s_q.fcnt;
            end else if (ra[11:2] == `MFF_R_DSTHI >> 2) begin
                rd = {16'h0000, s_q.dst[47:32]};
            end else if (ra[11:2] == `MFF_R_DSTLO >> 2) begin
                rd = s_q.dst[31:0];
            end else if (ra[11:2] == `MFF_R_SRCHI >> 2) begin
                rd = {16'h0000, s_q.src[47:32]};
            end else if (ra[11:2] == `MFF_R_SRCLO >> 2) begin
                rd = s_q.src[31:0];
            end else if (ra[11:2] == `MFF_R_SNAP >> 2) begin
                rd = {16'h0000, s_q.snap};
            end else if (ra[11:2] == `MFF_R_RXMASK >> 2) begin
                rd = s_q.rx_mask;
            end else if (ra[11:2] == `MFF_R_RXCNT >> 2) begin
                rd = s_q.rx_cnt;
            end else if (ra >= `MFF_R_TXSLOT && ra < `MFF_R_RXSLOT) begin
                rd = tx_mem[ra[6:2]];
            end else if (ra >= `MFF_R_RXSLOT && ra < `MFF_R_END) begin
                rd = rx_word(s_q.bank, ra[6:2]);
            end
            s_d.rdata = rd;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Two receive banks: a frame only becomes visible once its FCS passed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.tx_st <= mff_pkg::MFF_TX_IDLE;
            s_q.tx_crc <= `MFF_CRC_INIT;
            s_q.rx_crc <= `MFF_CRC_INIT;
            s_q.ctrl <= `MFF_CTRL_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge hclk) begin
        if (ce && tx_wr) begin
            tx_mem[tx_wa] <= hwdata;
        end
        if (ce && rx_wr) begin
            rx_mem[rx_wa] <= rx_data;
        end
    end

    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign tx_data = s_q.tx_data;
    assign tx_valid = s_q.tx_st == mff_pkg::MFF_TX_SEND;
    assign tx_last = tx_valid && s_q.tx_idx == `MFF_LAST_IDX;
    assign rx_frame_ok = s_q.ok_p;
    assign rx_frame_err = s_q.err_p;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_tx_preamble: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE2]
        tx_valid && s_q.tx_idx < 8'd7 |-> tx_data == `MFF_PRE_BYTE)
        else $error("preamble octet wrong");
    a_tx_length: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE4]
        tx_valid && s_q.tx_idx == `MFF_LEN_LO |-> tx_data == 8'hC4)
        else $error("length octet wrong");
    a_tx_llc: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE5]
        tx_valid && s_q.tx_idx == `MFF_LLC_CTL |-> tx_data == `MFF_LLC_CTL_VAL)
        else $error("llc control wrong");
    a_tx_snap_zero: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE6]
        tx_valid && s_q.tx_idx >= `MFF_SNAP_ZERO && s_q.tx_idx < `MFF_SNAP_OPEN
        |-> tx_data == 8'h00)
        else $error("snap prefix not zero");
    a_tx_version: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
        tx_valid && s_q.tx_idx == `MFF_CFG0 |-> tx_data[3:0] == 4'h3 && !tx_data[6])
        else $error("version or reserved bit wrong");
    a_tx_end_len: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE1]
        ce && tx_last && tx_ready |=> !tx_valid && s_q.tx_idx == `MFF_LAST_IDX)
        else $error("frame did not end at octet 221");
    a_tx_fcs_seq: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE7]
        ce && tx_valid && tx_ready && s_q.tx_idx == 8'd217
        |=> tx_data == ~s_q.tx_crc[31:24])
        else $error("fcs octet wrong");
    a_rx_drop: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE22]
        ce && rx_valid && rx_last && s_q.rx_bad |=> rx_frame_err && !rx_frame_ok)
        else $error("bad frame not dropped");
    a_rx_bank: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE12]
        ce && rx_frame_ok |-> s_q.rx_cfg0[3:0] == 4'h3 && s_q.bank != $past(s_q.bank))
        else $error("bank flipped on bad config");
endmodule : mff_formatter

// >>> rtl/mff_pkg.sv
package mff_pkg;
    typedef enum logic [1:0] {
        MFF_TX_IDLE = 2'b01,
        MFF_TX_SEND = 2'b10
    } mff_tx_state_t;
    typedef enum logic [1:0] {
        MFF_ENC_INT = 2'h0,
        MFF_ENC_FLOAT = 2'h1,
        MFF_ENC_A24 = 2'h2,
        MFF_ENC_RAW = 2'h3
    } mff_enc_t;
endpackage : mff_pkg

// >>> tb/mff_peer.sv
`timescale 1ns/1ns
// ----------------------------------------
// Peer node: sinks the tx stream with stalls, sources rx frames with gaps
// ----------------------------------------
module mff_peer (
    input wire logic hclk,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_last
);
    logic [7:0] cap [222];
    int n = 0;
    int len = 0;
    int done = 0;
    int ph = 0;
    initial begin
        tx_ready = 1'b0;
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_last = 1'b0;
    end
    // Stall one cycle in three so tx_data must hold until taken
    always @(posedge hclk) begin
        ph <= (ph + 1) % 3;
        tx_ready <= (ph != 2);
        if (tx_valid && tx_ready) begin
            cap[n % 222] <= tx_data;
            n <= tx_last ? 0 : n + 1;
            if (tx_last) begin
                len <= n + 1;
                done <= done + 1;
            end
        end
    end
    // Frames leave whole, 222 octets, with idle gaps between some octets
    task automatic send(input logic [7:0] f [222]);
        for (int i = 0; i < 222; i++) begin
            if (i % 5 == 4) begin
                @(posedge hclk);
                rx_valid <= 1'b0;
                // Idle line never shows the last octet again
                rx_data <= ~rx_data;
            end
            @(posedge hclk);
            rx_data <= f[i];
            rx_valid <= 1'b1;
            rx_last <= (i == 221);
        end
        @(posedge hclk);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~rx_data;
    endtask : send
endmodule : mff_peer

// >>> tb/tb_media_frame_formatter.sv
`timescale 1ns/1ns
`include "mff_defines.svh"
module tb_media_frame_formatter;
    logic hclk = 0, hresetn = 0, hwrite = 0, tx_frame_req = 0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
    logic [1:0] htrans = 2'h0;
    logic hready, hresp, tx_valid, tx_last, tx_ready, rx_valid, rx_last, rx_ok, rx_err;
    logic [7:0] tx_data, rx_data;
    logic [7:0] f [222];
    int err_count = 0, num_checks = 0, cyc = 0;
    mff_formatter dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .tx_frame_req(tx_frame_req), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_last(rx_last), .rx_frame_ok(rx_ok), .rx_frame_err(rx_err));
    mff_peer peer_u (.hclk(hclk), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_last(rx_last));
    initial forever #5 hclk = ~hclk;
    // Whole run needs about 2800 cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : cmp
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rv = hrdata;
    endtask : ahb
    function automatic logic [31:0] fcs(input logic [7:0] b [222]);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        for (int i = 8; i < 218; i++) begin
            c ^= {24'h0, b[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        end
        return ~c;
    endfunction : fcs
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        ahb(0, `MFF_R_CTRL, 0);
        cmp("ctrl reset", 32'h0, rv);
        ahb(1, 12'h200, 32'hFFFFFFFF);
        ahb(0, 12'h200, 0);
        cmp("unmapped", 32'h0, rv);
        cmp("hresp", 32'h0, {31'h0, hresp});
        $display("test regs done");
    endtask : t_regs
    task automatic t_rx();
        logic [7:0] idx [5] = '{8'd30, 8'd100, 8'd21, 8'd30, 8'd30};
        logic [7:0] val [5] = '{8'hA3, 8'h5A, 8'hC5, 8'hA4, 8'hE3};
        for (int k = 0; k < 5; k++) begin
            for (int i = 0; i < 222; i++)
                f[i] = (i < 7) ? 8'h55 : (i < 20) ? i[7:0] : 8'h00;
            f[7] = 8'hD5;
            f[21] = 8'hC4;
            {f[22], f[23], f[24], f[28], f[29]} = 40'hAAAA031234;
            {f[31], f[41], f[42], f[43], f[45]} = 40'h0101CAFE01;
            f[idx[k]] = val[k];
            {f[218], f[219], f[220], f[221]} = fcs(f);
            if (k == 1)
                f[idx[k]] = 8'h00;
            peer_u.send(f);
            #1;
            cmp("rx ok", {31'h0, k == 0 || k == 4}, {31'h0, rx_ok});
            cmp("rx err", {31'h0, k > 0 && k < 4}, {31'h0, rx_err});
        end
        ahb(0, `MFF_R_RXSLOT, 0);
        cmp("rx slot0", 32'hCAFE0001, rv);
        ahb(0, `MFF_R_STAT, 0);
        cmp("stat", {16'h3, 2'h0, 4'h1, 8'hA3, 2'h2}, rv);
        $display("test rx done");
    endtask : t_rx
    task automatic t_tx();
        logic [7:0] e [222];
        logic [31:0] m;
        int w;
        ahb(1, `MFF_R_DSTHI, 32'hA1B2);
        ahb(1, `MFF_R_DSTLO, 32'hC3D4E5F6);
        ahb(1, `MFF_R_SRCHI, 32'h0102);
        ahb(1, `MFF_R_SRCLO, 32'h03040506);
        ahb(1, `MFF_R_SNAP, 32'hBEEF);
        ahb(1, `MFF_R_TXMASK, 32'h3);
        for (int s = 0; s < 32; s++)
            ahb(1, `MFF_R_TXSLOT + 12'(4 * s), s == 0 ? 32'h12345678 : s == 1 ? '1 : 0);
        for (int enc = 0; enc < 4; enc++) begin
            // Width 16 and rate following from the uplink
            ahb(1, `MFF_R_CTRL, 32'h4021 | (enc << 1));
            m = enc == 3 ? 32'hFFFFFFFF : enc == 2 ? 32'hFFFF00FF : 32'hFFFF0000;
            for (int i = 0; i < 222; i++)
                e[i] = (i < 7) ? 8'h55 : 8'h00;
            {e[7], e[8], e[9], e[10], e[11], e[12], e[13]} = 56'hD5A1B2C3D4E5F6;
            {e[16], e[17], e[18], e[19], e[21]} = 40'h03040506C4;
            e[14] = 8'h01;
            e[15] = 8'h02;
            {e[22], e[23], e[24], e[28], e[29]} = 40'hAAAA03BEEF;
            {e[30], e[31], e[41]} = {2'h2, enc[1:0], 4'h3, 8'h01, 8'h03};
            {e[42], e[43], e[44], e[45]} = 32'h12345678 & m;
            {e[46], e[47], e[48], e[49]} = m;
            e[37] = 8'(enc);
            w = peer_u.done;
            @(posedge hclk);
            tx_frame_req <= 1'b1;
            @(posedge hclk);
            tx_frame_req <= 1'b0;
            for (int t = 0; t < 2000 && peer_u.done == w; t++)
                @(posedge hclk);
            #1;
            cmp("tx frame done", w + 1, peer_u.done);
            cmp("tx length", 222, peer_u.len);
            for (int i = 0; i < 218; i++)
                cmp($sformatf("tx octet %0d", i), e[i], peer_u.cap[i]);
            cmp("tx fcs", fcs(peer_u.cap), {peer_u.cap[218], peer_u.cap[219],
                peer_u.cap[220], peer_u.cap[221]});
        end
        ahb(0, `MFF_R_FCNT, 0);
        cmp("frame count", 32'h4, rv);
        $display("test tx done");
    endtask : t_tx
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_rx();
        t_tx();
        end_sim();
    end
endmodule : tb_media_frame_formatter
